// [rtl/okr_pkg.sv]
// Operation
// - Sweep-select low gives fixed LO; high gives swept LO.
// - Control inputs default high when left unconnected (pull-up).
// - Two bandwidth selects pick one of four binary-stepped filter bandwidths.
// - Code high,low: 11 widest, 10 half, 01 quarter, 00 narrowest.
// - LO ratio is 32.5 in fixed mode, 32.25 in sweep mode.
// - Sweep mode steps LO through a fixed sequence over about 1.5 percent.
// - AGC decay constant is fixed at ten times the attack constant.
// - Power-down disables both AGC currents so the capacitor holds.
// - Leaving power-down boosts AGC currents 45 times for a fixed interval.
// - Boost interval timed from reference, 10.9 ms at 6 MHz.
// - Power-down high means standby; receiver runs only while it is low.
// - All timing and tuning derive from the reference oscillator.
// - Data output compares demodulated signal against its filtered average.
// - Wake output goes low on detecting a steady carrier header.
// - Wake detection is inactive during power-down.
// - Wake counter runs on an internal tick of about 23.4 kHz.
// - After 128 ticks of unbroken carrier, wake goes low until data starts.
package okr_pkg;
  // Reference rate seen by this logic (system clock stands in for the oscillator)
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned REF_HZ = 6_000_000;
  // Wake tick: reference divided by 256 gives about 23.4 kHz
  localparam int unsigned WAKE_REF_DIV = 256;
  localparam int unsigned WAKE_TICK_CYC = (CLK_HZ / REF_HZ) * WAKE_REF_DIV;
  localparam int unsigned WAKE_COUNT = 128;
  // Boost interval in microseconds at the reference rate
  localparam int unsigned BOOST_US = 10_900;
  localparam int unsigned BOOST_CYC = (CLK_HZ / 1_000_000) * BOOST_US;
  // AGC gain ratios
  localparam logic [5:0] AGC_BOOST_GAIN = 6'h2D;
  localparam logic [3:0] AGC_DECAY_RATIO = 4'hA;
  // LO ratio in quarters: 130/4 = 32.5, 129/4 = 32.25
  localparam logic [7:0] LO_QTR_FIXED = 8'h82;
  localparam logic [7:0] LO_QTR_SWEEP = 8'h81;
  // Sweep sequence: 16 steps, signed offset in LO fine units
  localparam int unsigned SWEEP_STEPS = 16;
  localparam int unsigned SWEEP_STEP_CYC = 64;
  // Bandwidth in Hz, sweep mode narrowest; fixed mode doubles it
  localparam logic [15:0] BW_SWEEP_MIN_HZ = 16'h0226;
  // Reset values of the outputs
  localparam logic WAKE_N_RST = 1'b1;

  typedef enum logic [1:0] {
    OKR_WK_IDLE = 2'b00,
    OKR_WK_COUNT = 2'b01,
    OKR_WK_AWAKE = 2'b11
  } okr_wake_e;

  // Tuning outputs handed to the analog front end
  typedef struct packed {
    logic sweep_mode;
    logic [7:0] lo_ratio_qtr;
    logic [3:0] sweep_step;
    logic [15:0] bw_hz;
  } okr_tune_s;

  // AGC current control
  typedef struct packed {
    logic enable;
    logic [5:0] gain;
    logic [3:0] decay_ratio;
  } okr_agc_s;
endpackage

// [rtl/okr_ctrl.sv]
`timescale 1ns/1ps
module okr_ctrl #(
  parameter int unsigned BOOST_CYCLES = okr_pkg::BOOST_CYC,
  parameter int unsigned WAKE_TICK_CYCLES = okr_pkg::WAKE_TICK_CYC,
  parameter int unsigned WAKE_TICKS = okr_pkg::WAKE_COUNT
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Control pins, already pulled up at the pad
  input wire logic sweep_select_in,
  input wire logic bw_select_lo_in,
  input wire logic bw_select_hi_in,
  input wire logic power_down_in,
  // Demodulator comparator result and carrier presence
  input wire logic slice_above_in,
  input wire logic carrier_in,
  // Outputs
  output okr_pkg::okr_tune_s tune_out,
  output okr_pkg::okr_agc_s agc_out,
  output logic data_out,
  output logic carrier_wake_n_out,
  output logic standby_out
);
  import okr_pkg::*;

  // Bandwidth lookup on {hi, lo}: plain binary code, 11 widest down to 00 narrowest
  function automatic logic [15:0] bw_lookup(input logic hi, input logic lo, input logic sweep);
    logic [3:0] mult;
    logic [15:0] base;
    mult = 4'h1;
    base = sweep ? BW_SWEEP_MIN_HZ : 16'(BW_SWEEP_MIN_HZ << 1);
    case ({hi, lo})
      2'b11: mult = 4'h8;
      2'b10: mult = 4'h4;
      2'b01: mult = 4'h2;
      default: mult = 4'h1;
    endcase
    return 16'(base * mult);
  endfunction

  // Two-flop synchronisers for all pin inputs; reset loads the four control pins high to mirror the pull-ups, slice and carrier low
  logic [5:0] sync1_q, sync1_d, sync2_q, sync2_d;
  always_comb begin
    sync1_d = {sweep_select_in, bw_select_lo_in, bw_select_hi_in, power_down_in, slice_above_in, carrier_in};
    sync2_d = sync1_q;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sync1_q <= 6'h3C;
      sync2_q <= 6'h3C;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic sweep_s, bw_lo_s, bw_hi_s, pd_s, slice_s, carrier_s;
  assign {sweep_s, bw_lo_s, bw_hi_s, pd_s, slice_s, carrier_s} = sync2_q;

  // Power-down edge tracking and AGC boost timer
  logic pd_prev_q, pd_prev_d;
  logic [31:0] boost_cnt_q, boost_cnt_d;
  logic boost_q, boost_d;
  always_comb begin
    pd_prev_d = pd_s;
    boost_cnt_d = boost_cnt_q;
    boost_d = boost_q;
    if (pd_s) begin
      boost_d = 1'b0;
      boost_cnt_d = '0;
    end else if (pd_prev_q) begin
      // Restart on every release so a short standby still gets a full boost
      boost_cnt_d = '0;
      boost_d = 1'b1;
    end else if (boost_q) begin
      if (boost_cnt_q >= BOOST_CYCLES - 1) begin
        boost_d = 1'b0;
      end else begin
        boost_cnt_d = boost_cnt_q + 32'h0000_0001;
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pd_prev_q <= 1'b1;
      boost_cnt_q <= '0;
      boost_q <= 1'b0;
    end else begin
      pd_prev_q <= pd_prev_d;
      boost_cnt_q <= boost_cnt_d;
      boost_q <= boost_d;
    end
  end

  // Sweep sequencer: a deterministic ramp much faster than any data bit
  logic [7:0] sweep_div_q, sweep_div_d;
  logic [3:0] sweep_step_q, sweep_step_d;
  always_comb begin
    sweep_div_d = sweep_div_q;
    sweep_step_d = sweep_step_q;
    if (!sweep_s || pd_s) begin
      sweep_div_d = '0;
      sweep_step_d = '0;
    end else if (sweep_div_q == 8'(SWEEP_STEP_CYC - 1)) begin
      sweep_div_d = '0;
      sweep_step_d = 4'(sweep_step_q + 4'h1);
    end else begin
      sweep_div_d = 8'(sweep_div_q + 8'h01);
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sweep_div_q <= '0;
      sweep_step_q <= '0;
    end else begin
      sweep_div_q <= sweep_div_d;
      sweep_step_q <= sweep_step_d;
    end
  end

  // Wake-up detector: tick divider, carrier counter and state
  okr_wake_e wk_q, wk_d;
  logic [31:0] tick_div_q, tick_div_d;
  logic [7:0] wk_cnt_q, wk_cnt_d;
  logic wake_n_q, wake_n_d;
  logic tick;
  assign tick = (tick_div_q == WAKE_TICK_CYCLES - 1);
  always_comb begin
    wk_d = wk_q;
    wk_cnt_d = wk_cnt_q;
    wake_n_d = wake_n_q;
    tick_div_d = tick ? '0 : tick_div_q + 32'h0000_0001;
    if (pd_s) begin
      // Detector held idle in standby
      wk_d = OKR_WK_IDLE;
      wk_cnt_d = '0;
      wake_n_d = WAKE_N_RST;
      tick_div_d = '0;
    end else begin
      case (wk_q)
        OKR_WK_IDLE: begin
          wk_cnt_d = '0;
          if (carrier_s) begin
            wk_d = OKR_WK_COUNT;
          end
        end
        OKR_WK_COUNT: begin
          if (!carrier_s) begin
            wk_cnt_d = '0;
            wk_d = OKR_WK_IDLE;
          end else if (tick) begin
            if (wk_cnt_q == 8'(WAKE_TICKS - 1)) begin
              wake_n_d = 1'b0;
              wk_d = OKR_WK_AWAKE;
            end else begin
              wk_cnt_d = 8'(wk_cnt_q + 8'h01);
            end
          end
        end
        OKR_WK_AWAKE: begin
          // Carrier dropping marks the start of data
          if (!carrier_s) begin
            wake_n_d = 1'b1;
            wk_cnt_d = '0;
            wk_d = OKR_WK_IDLE;
          end
        end
        default: begin
          wk_d = OKR_WK_IDLE;
          wake_n_d = WAKE_N_RST;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wk_q <= OKR_WK_IDLE;
      tick_div_q <= '0;
      wk_cnt_q <= '0;
      wake_n_q <= WAKE_N_RST;
    end else begin
      wk_q <= wk_d;
      tick_div_q <= tick_div_d;
      wk_cnt_q <= wk_cnt_d;
      wake_n_q <= wake_n_d;
    end
  end

  // Registered outputs: tuning, AGC control, data slicer, standby
  okr_tune_s tune_q, tune_d;
  okr_agc_s agc_q, agc_d;
  logic data_q, data_d, standby_q, standby_d;
  always_comb begin
    tune_d.sweep_mode = sweep_s;
    tune_d.lo_ratio_qtr = sweep_s ? LO_QTR_SWEEP : LO_QTR_FIXED;
    tune_d.sweep_step = sweep_step_q;
    tune_d.bw_hz = bw_lookup(bw_hi_s, bw_lo_s, sweep_s);
    agc_d.enable = !pd_s;
    agc_d.gain = boost_q ? AGC_BOOST_GAIN : 6'h01;
    agc_d.decay_ratio = AGC_DECAY_RATIO;
    data_d = pd_s ? 1'b0 : slice_s;
    standby_d = pd_s;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      tune_q <= '0;
      agc_q <= '0;
      data_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      tune_q <= tune_d;
      agc_q <= agc_d;
      data_q <= data_d;
      standby_q <= standby_d;
    end
  end

  assign tune_out = tune_q;
  assign agc_out = agc_q;
  assign data_out = data_q;
  assign carrier_wake_n_out = wake_n_q;
  assign standby_out = standby_q;
endmodule

// [dv/okr_ctrl_properties.sv]
`timescale 1ns/1ps
module okr_ctrl_properties #(
  parameter int unsigned BOOST_CYCLES = okr_pkg::BOOST_CYC,
  parameter int unsigned WAKE_TICK_CYCLES = okr_pkg::WAKE_TICK_CYC,
  parameter int unsigned WAKE_TICKS = okr_pkg::WAKE_COUNT
) (
  // Clock, reset and pins
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic sweep_select_in,
  input wire logic bw_select_lo_in,
  input wire logic bw_select_hi_in,
  input wire logic power_down_in,
  input wire logic slice_above_in,
  input wire logic carrier_in,
  // Block outputs
  input okr_pkg::okr_tune_s tune_out,
  input okr_pkg::okr_agc_s agc_out,
  input wire logic data_out,
  input wire logic carrier_wake_n_out,
  input wire logic standby_out
);
  import okr_pkg::*;
  localparam int WAKE_MIN = (WAKE_TICKS - 1) * WAKE_TICK_CYCLES;
  localparam int WAKE_MAX = (WAKE_TICKS + 1) * WAKE_TICK_CYCLES + 8;
  logic [1:0] up_q, up_d;
  logic [31:0] bc_q, bc_d, cr_q, cr_d;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Settle count, boost run, raw carrier run; 32 bits so the full-length boost still fits
  always_comb begin
    up_d = !resetn_in ? 2'h0 : up_q + {1'b0, up_q != 2'h3};
    bc_d = (agc_out.enable && agc_out.gain == AGC_BOOST_GAIN) ? bc_q + 32'h0000_0001 : 32'h0000_0000;
    cr_d = (carrier_in && !standby_out) ? cr_q + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clk_sys_in) begin
    up_q <= up_d;
    bc_q <= bc_d;
    cr_q <= cr_d;
  end
  mode_ratio_a: assert property (up_q == 2'h3 |-> tune_out.sweep_mode == $past(sweep_select_in, 3) &&
    tune_out.lo_ratio_qtr == (tune_out.sweep_mode ? LO_QTR_SWEEP : LO_QTR_FIXED)) else $error("LO mode wrong");
  bandwidth_a: assert property (up_q == 2'h3 |-> tune_out.bw_hz ==
    ((BW_SWEEP_MIN_HZ << {$past(bw_select_hi_in, 3), $past(bw_select_lo_in, 3)}) << !$past(sweep_select_in, 3)))
    else $error("bandwidth wrong");
  standby_copy_a: assert property (up_q == 2'h3 |-> standby_out == $past(power_down_in, 3))
    else $error("standby lags pin");
  standby_hold_a: assert property (standby_out && $past(standby_out) |-> !agc_out.enable && carrier_wake_n_out)
    else $error("active in standby");
  boost_start_a: assert property ($fell(standby_out) |-> ##[0:3] agc_out.gain == AGC_BOOST_GAIN)
    else $error("no boost");
  boost_len_a: assert property (agc_out.enable && agc_out.gain != AGC_BOOST_GAIN && bc_q != 32'h0000_0000 |->
    bc_q == BOOST_CYCLES) else $error("boost length wrong");
  wake_min_a: assert property ($fell(carrier_wake_n_out) |-> cr_q >= WAKE_MIN) else $error("early wake");
  wake_on_a: assert property (cr_q == WAKE_MAX |-> !carrier_wake_n_out) else $error("missed wake");
  cover property ($fell(carrier_wake_n_out));
  cover property ($fell(standby_out));
  cover property ($rose(tune_out.sweep_mode));
endmodule
bind okr_ctrl okr_ctrl_properties #(.BOOST_CYCLES(BOOST_CYCLES), .WAKE_TICK_CYCLES(WAKE_TICK_CYCLES),
  .WAKE_TICKS(WAKE_TICKS)) u_props (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .sweep_select_in(sweep_select_in), .bw_select_lo_in(bw_select_lo_in), .bw_select_hi_in(bw_select_hi_in),
  .power_down_in(power_down_in), .slice_above_in(slice_above_in), .carrier_in(carrier_in),
  .tune_out(tune_out), .agc_out(agc_out), .data_out(data_out), .carrier_wake_n_out(carrier_wake_n_out),
  .standby_out(standby_out));

// [dv/okr_tx_model.sv]
`timescale 1ns/1ps
module okr_tx_model (
  // Clock and burst request
  input wire logic clk_sys_in,
  input wire logic start_in,
  input wire logic [15:0] burst_in,
  // Demodulated carrier as the receiver sees it
  output logic carrier_out,
  output logic slice_out
);
  logic [15:0] n_q = 16'h0000;
  logic [15:0] n_d;
  // Frame position: header, then 64 cycles of keyed data, then silence
  always_comb begin
    n_d = 16'h0000;
    if (start_in) begin
      n_d = 16'h0001;
    end else if (n_q != 16'h0000 && n_q < burst_in + 16'h0040) begin
      n_d = n_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    n_q <= n_d;
  end
  // Bits 8 cycles wide, so data alone never looks like a header
  assign carrier_out = (n_q != 16'h0000) && (n_q <= burst_in || n_q[3]);
  assign slice_out = carrier_out;
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import okr_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sw = 1'b1, lo = 1'b1, hi = 1'b1, pd = 1'b1, start = 1'b0;
  logic [15:0] burst = 16'h0000;
  logic carrier, slice, data, wake_n, stby;
  logic [3:0] step;
  okr_tune_s tune;
  okr_agc_s agc;
  int errors = 0;
  int comparisons = 0;
  // 200 MHz system clock
  always #2.5 clk_sys_in = ~clk_sys_in;
  okr_ctrl #(.BOOST_CYCLES(50), .WAKE_TICK_CYCLES(4), .WAKE_TICKS(8)) dut (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .sweep_select_in(sw), .bw_select_lo_in(lo), .bw_select_hi_in(hi),
    .power_down_in(pd), .slice_above_in(slice), .carrier_in(carrier), .tune_out(tune), .agc_out(agc),
    .data_out(data), .carrier_wake_n_out(wake_n), .standby_out(stby));
  okr_tx_model tx (.clk_sys_in(clk_sys_in), .start_in(start), .burst_in(burst), .carrier_out(carrier),
    .slice_out(slice));
  // Waits end 1 ns past the edge so its updates have landed
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic check(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic pulse(input logic [15:0] len);
    @(posedge clk_sys_in) burst <= len;
    start <= 1'b1;
    @(posedge clk_sys_in) start <= 1'b0;
  endtask
  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in) {sw, hi, lo} <= i[2:0];
      w(5);
      check(tune.sweep_mode === i[2] && tune.lo_ratio_qtr === (i[2] ? LO_QTR_SWEEP : LO_QTR_FIXED), "ratio");
      check(tune.bw_hz === ((BW_SWEEP_MIN_HZ << i[1:0]) << !i[2]), "bandwidth");
      if (!i[2]) begin
        check(tune.sweep_step === 4'h0, "step moves in fixed mode");
      end
    end
    step = tune.sweep_step;
    w(64);
    check(tune.sweep_step === 4'(step + 4'h1), "sweep step stuck");
    $display("modes done");
  endtask
  // Second standby starts mid-boost, so a timer that does not restart on release expires early
  task automatic t_boost;
    @(posedge clk_sys_in) pd <= 1'b1;
    w(6);
    check(agc.enable === 1'b0 && stby === 1'b1, "standby");
    @(posedge clk_sys_in) pd <= 1'b0;
    w(6);
    check(agc.enable === 1'b1 && agc.gain === AGC_BOOST_GAIN, "boost on");
    w(20);
    @(posedge clk_sys_in) pd <= 1'b1;
    w(6);
    @(posedge clk_sys_in) pd <= 1'b0;
    w(40);
    check(agc.gain === AGC_BOOST_GAIN, "boost restart");
    w(25);
    check(agc.gain === 6'h01 && agc.decay_ratio === 4'hA, "boost end");
    $display("boost done");
  endtask
  task automatic t_wake;
    pulse(16'h0014);
    w(40);
    check(wake_n === 1'b1, "short header");
    w(60);
    pulse(16'h003C);
    w(50);
    check(wake_n === 1'b0, "no wake");
    check(data === 1'b1, "data not following slice");
    w(25);
    check(wake_n === 1'b1, "wake held in data");
    w(60);
    @(posedge clk_sys_in) pd <= 1'b1;
    pulse(16'h003C);
    w(50);
    check(wake_n === 1'b1, "wake in standby");
    check(data === 1'b0 && stby === 1'b1, "data in standby");
    $display("wake done");
  endtask
  initial begin
    w(7);
    check(tune === okr_tune_s'(0) && agc === okr_agc_s'(0) && wake_n === 1'b1 && stby === 1'b1 && data === 1'b0,
      "reset");
    @(posedge clk_sys_in) resetn_in <= 1'b1;
    pd <= 1'b0;
    t_modes;
    t_boost;
    t_wake;
    tally_and_finish;
  end
  // Run needs about 520 cycles
  initial begin
    #20000;
    errors++;
    $display("[FAIL] %0t watchdog", $time);
    tally_and_finish;
  end
endmodule
